// File: pcor_hold_gen.sv
// Purpose: internal pll hold window around vertical sync
// Assumes: line_tick is one pulse per line, vsync is already synchronised
// Notes: the line count of the previous frame predicts where the next vsync starts
`timescale 1ns/1ps
module pcor_hold_gen
    import pcor_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // timing
    input wire logic line_tick,
    input wire logic vsync,
    // settings
    input wire logic [7:0] hold_pre,
    input wire logic [7:0] hold_post,
    // result
    output logic hold
);

    pcor_hold_state_t st;
    pcor_hold_state_t next_st;
    logic [12:0] lines_ahead;

    assign lines_ahead = {1'b0, st.line_cnt} + {5'h00, hold_pre};

    always_comb begin
        next_st = st;
        next_st.vs_d = vsync;
        if (vsync && !st.vs_d) begin
            next_st.frame_lines = st.line_cnt;
            next_st.line_cnt = 12'h000;
        end else if (line_tick && st.line_cnt != 12'hfff) begin
            next_st.line_cnt = st.line_cnt + 12'h001;
        end
        // post window restarts on vsync end, then counts down per line
        if (!vsync && st.vs_d) begin
            next_st.post_left = hold_post;
        end else if (line_tick && st.post_left != 8'h00) begin
            next_st.post_left = st.post_left - 8'h01;
        end
        // unknown frame length: no prediction, so no early hold
        next_st.hold = vsync || (st.post_left != 8'h00) ||
            (st.frame_lines != 12'h000 && lines_ahead >= {1'b0, st.frame_lines});
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hold = st.hold;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_pre_window: assert property (st.frame_lines != 12'h000 &&
        lines_ahead >= {1'b0, st.frame_lines} |=> hold)
        else $error("hold missing before vsync");
    a_post_window: assert property ($fell(vsync) && hold_post != 8'h00 |=> ##1 hold)
        else $error("hold missing after vsync");
    a_vsync_hold: assert property (vsync |=> hold)
        else $error("hold missing during vsync");

endmodule

// File: pcor_pkg.sv
// Purpose: shared constants, types and helpers of the pll, clamp and offset register bank
// Assumes: avalon-mm word per register, byte address = 4 * register index
// Notes: register state is kept masked so that unused bits read back as zero
package pcor_pkg;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_RED_OFS_LO = 6'h19;
    localparam logic [5:0] IDX_GRN_OFS_HI = 6'h1a;
    localparam logic [5:0] IDX_GRN_OFS_LO = 6'h1b;
    localparam logic [5:0] IDX_BLU_OFS_HI = 6'h1c;
    localparam logic [5:0] IDX_BLU_OFS_LO = 6'h1d;
    localparam logic [5:0] IDX_LEN_HI = 6'h1e;
    localparam logic [5:0] IDX_LEN_LO = 6'h1f;
    localparam logic [5:0] IDX_PHASE = 6'h20;
    localparam logic [5:0] IDX_HOLD_PRE = 6'h21;
    localparam logic [5:0] IDX_HOLD_POST = 6'h22;
    localparam logic [5:0] IDX_SRC_CTRL = 6'h23;
    localparam logic [5:0] IDX_CLAMP_HI = 6'h24;
    localparam logic [5:0] IDX_CLAMP_LO = 6'h25;
    localparam logic [5:0] IDX_CLAMP_WIDTH = 6'h26;
    localparam logic [5:0] IDX_FRONT_CTRL = 6'h30;
    localparam logic [5:0] IDX_STATUS = 6'h31;

    // reset values
    localparam logic [7:0] RST_OFS_HI = 8'h80;
    localparam logic [7:0] RST_OFS_LO = 8'h00;
    localparam logic [7:0] RST_LEN_HI = 8'h06;
    localparam logic [7:0] RST_LEN_LO = 8'h98;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_HOLD_LINES = 8'h04;
    localparam logic [7:0] RST_SRC_CTRL = 8'h00;
    localparam logic [7:0] RST_CLAMP_HI = 8'h00;
    localparam logic [7:0] RST_CLAMP_LO = 8'h02;
    localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
    localparam logic [7:0] RST_FRONT_CTRL = 8'h01;

    // writable bit masks
    localparam logic [7:0] MASK_LSB_PAIR = 8'hc0;
    localparam logic [7:0] MASK_SIX = 8'h3f;
    localparam logic [7:0] MASK_SRC_CTRL = 8'h1f;
    localparam logic [7:0] MASK_FRONT_CTRL = 8'h03;

    // field positions
    localparam int SRC_LOCK_EDGE = 0;
    localparam int SRC_CLOCK_INVERT_PIN_EN = 1;
    localparam int SRC_HOLD_EXT = 2;
    localparam int SRC_HOLD_POL = 3;
    localparam int SRC_EXT_CLK = 4;
    localparam int FRONT_BLACK_CORR = 0;
    localparam int FRONT_DC_COUPLED = 1;

    // offset word mid code, one phase step in thousandths of a degree (64 steps per period)
    localparam logic [9:0] OFS_MID = 10'h200;
    localparam int PHASE_STEP_MDEG = 5625;
    localparam logic [13:0] PIX_CNT_MAX = 14'h3fff;

    typedef struct packed {
        logic [7:0] red_ofs_lo;
        logic [7:0] grn_ofs_hi;
        logic [7:0] grn_ofs_lo;
        logic [7:0] blu_ofs_hi;
        logic [7:0] blu_ofs_lo;
        logic [7:0] len_hi;
        logic [7:0] len_lo;
        logic [7:0] phase;
        logic [7:0] hold_pre;
        logic [7:0] hold_post;
        logic [7:0] src_ctrl;
        logic [7:0] clamp_hi;
        logic [7:0] clamp_lo;
        logic [7:0] clamp_width;
        logic [7:0] front_ctrl;
    } pcor_regs_t;

    typedef struct packed {
        logic [11:0] line_cnt;
        logic [11:0] frame_lines;
        logic [7:0] post_left;
        logic vs_d;
        logic hold;
    } pcor_hold_state_t;

    // 10-bit word from a high byte and the two lsbs in bits 7:6 of the low byte
    function automatic logic [9:0] pcor_ofs_word(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo[7:6]};
    endfunction

    // signed digital offset: mid code means zero
    function automatic logic [9:0] pcor_ofs_signed(input logic [9:0] w);
        return {~w[9], w[8:0]};
    endfunction

    function automatic pcor_regs_t pcor_regs_reset();
        pcor_regs_t r;
        r.red_ofs_lo = RST_OFS_LO;
        r.grn_ofs_hi = RST_OFS_HI;
        r.grn_ofs_lo = RST_OFS_LO;
        r.blu_ofs_hi = RST_OFS_HI;
        r.blu_ofs_lo = RST_OFS_LO;
        r.len_hi = RST_LEN_HI;
        r.len_lo = RST_LEN_LO;
        r.phase = RST_PHASE;
        r.hold_pre = RST_HOLD_LINES;
        r.hold_post = RST_HOLD_LINES;
        r.src_ctrl = RST_SRC_CTRL;
        r.clamp_hi = RST_CLAMP_HI;
        r.clamp_lo = RST_CLAMP_LO;
        r.clamp_width = RST_CLAMP_WIDTH;
        r.front_ctrl = RST_FRONT_CTRL;
        return r;
    endfunction

endpackage

// File: pcor_regs.sv
// Purpose: pll, clamp and offset control register bank with its timing logic
// Assumes: pins are asynchronous, pix_tick is a one-cycle pixel enable on clk_sys
// Notes: one wait state on every avalon access
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module pcor_regs
    import pcor_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // asynchronous pins
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    input wire logic ext_hold_pin,
    input wire logic clock_invert_pin,
    // pixel rate enable
    input wire logic pix_tick,
    // pll controls
    output logic [13:0] pll_line_length,
    output logic pll_line_length_load,
    output logic [5:0] sample_phase_steps,
    output logic pll_hold,
    output logic pll_lock_pulse,
    output logic clock_invert_out,
    output logic use_external_pixel_clock,
    // clamp and black sampling
    output logic clamp_on,
    output logic black_sample_start,
    // offsets
    output logic [1:0] red_offset_lsbs,
    output logic [9:0] green_offset_dac,
    output logic [9:0] blue_offset_dac,
    output logic [9:0] green_digital_offset,
    output logic [9:0] blue_digital_offset
);

    typedef struct packed {
        pcor_regs_t r;
        logic [1:0] hs_sy;
        logic [1:0] vs_sy;
        logic [1:0] eh_sy;
        logic [1:0] ci_sy;
        logic hs_d;
        logic waitreq;
        logic [31:0] rdata;
        logic [13:0] line_len;
        logic line_len_load;
        logic [13:0] pix_cnt;
        logic pix_run;
        logic [7:0] clamp_left;
        logic clamp_on;
        logic black_start;
        logic lock_pulse;
        logic clock_invert_pin_out;
        logic ext_clk_sel;
        logic hold;
        logic [9:0] grn_dac;
        logic [9:0] blu_dac;
        logic [9:0] grn_dig;
        logic [9:0] blu_dig;
        logic [1:0] red_lsbs;
        logic [5:0] phase_steps;
    } pcor_state_t;

    function automatic pcor_state_t pcor_state_reset();
        pcor_state_t s;
        s = '0;
        s.r = pcor_regs_reset();
        s.waitreq = 1'b1;
        s.line_len = {RST_LEN_HI[5:0], RST_LEN_LO};
        s.grn_dac = OFS_MID;
        s.blu_dac = OFS_MID;
        return s;
    endfunction

    localparam pcor_state_t ST_RESET = pcor_state_reset();

    pcor_state_t st;
    pcor_state_t next_st;
    logic hs_rise;
    logic hs_fall;
    logic [5:0] idx;
    logic req;
    logic wr_done;
    logic [7:0] wbyte;
    logic [13:0] clamp_start;
    logic start_hit;
    logic black_corr;
    logic dc_coupled;
    logic int_hold;
    logic [9:0] grn_word;
    logic [9:0] blu_word;
    logic [7:0] rd_byte;

    assign hs_rise = st.hs_sy[1] && !st.hs_d;
    assign hs_fall = !st.hs_sy[1] && st.hs_d;
    assign idx = avs_address[7:2];
    assign req = avs_read || avs_write;
    assign wr_done = avs_write && !st.waitreq && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign clamp_start = {st.r.clamp_hi[5:0], st.r.clamp_lo};
    assign start_hit = st.pix_run && pix_tick && st.pix_cnt == clamp_start;
    assign black_corr = st.r.front_ctrl[FRONT_BLACK_CORR];
    assign dc_coupled = st.r.front_ctrl[FRONT_DC_COUPLED];
    assign grn_word = pcor_ofs_word(st.r.grn_ofs_hi, st.r.grn_ofs_lo);
    assign blu_word = pcor_ofs_word(st.r.blu_ofs_hi, st.r.blu_ofs_lo);

    // internal hold runs on the raw trailing edge so lock edge choice cannot move it
    pcor_hold_gen u_hold (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .line_tick(hs_fall),
        .vsync(st.vs_sy[1]),
        .hold_pre(st.r.hold_pre),
        .hold_post(st.r.hold_post),
        .hold(int_hold)
    );

    // read mux; stored registers are already masked
    always_comb begin
        case (idx)
            IDX_RED_OFS_LO: rd_byte = st.r.red_ofs_lo;
            IDX_GRN_OFS_HI: rd_byte = st.r.grn_ofs_hi;
            IDX_GRN_OFS_LO: rd_byte = st.r.grn_ofs_lo;
            IDX_BLU_OFS_HI: rd_byte = st.r.blu_ofs_hi;
            IDX_BLU_OFS_LO: rd_byte = st.r.blu_ofs_lo;
            IDX_LEN_HI: rd_byte = st.r.len_hi;
            IDX_LEN_LO: rd_byte = st.r.len_lo;
            IDX_PHASE: rd_byte = st.r.phase;
            IDX_HOLD_PRE: rd_byte = st.r.hold_pre;
            IDX_HOLD_POST: rd_byte = st.r.hold_post;
            IDX_SRC_CTRL: rd_byte = st.r.src_ctrl;
            IDX_CLAMP_HI: rd_byte = st.r.clamp_hi;
            IDX_CLAMP_LO: rd_byte = st.r.clamp_lo;
            IDX_CLAMP_WIDTH: rd_byte = st.r.clamp_width;
            IDX_FRONT_CTRL: rd_byte = st.r.front_ctrl;
            IDX_STATUS: rd_byte = {4'h0, st.pix_run, st.ext_clk_sel, st.clamp_on, st.hold};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st;
        // two-flop synchronisers
        next_st.hs_sy = {st.hs_sy[0], hsync_pin};
        next_st.vs_sy = {st.vs_sy[0], vsync_pin};
        next_st.eh_sy = {st.eh_sy[0], ext_hold_pin};
        next_st.ci_sy = {st.ci_sy[0], clock_invert_pin};
        next_st.hs_d = st.hs_sy[1];

        // one wait state: waitrequest drops the cycle after a request is seen
        next_st.waitreq = !(req && st.waitreq);
        if (avs_read && st.waitreq) begin
            next_st.rdata = {24'h00_0000, rd_byte};
        end

        next_st.line_len_load = 1'b0;
        if (wr_done) begin
            case (idx)
                IDX_RED_OFS_LO: next_st.r.red_ofs_lo = wbyte & MASK_LSB_PAIR;
                IDX_GRN_OFS_HI: next_st.r.grn_ofs_hi = wbyte;
                IDX_GRN_OFS_LO: next_st.r.grn_ofs_lo = wbyte & MASK_LSB_PAIR;
                IDX_BLU_OFS_HI: next_st.r.blu_ofs_hi = wbyte;
                IDX_BLU_OFS_LO: next_st.r.blu_ofs_lo = wbyte & MASK_LSB_PAIR;
                IDX_LEN_HI: next_st.r.len_hi = wbyte & MASK_SIX;
                IDX_LEN_LO: begin
                    // high byte alone never reaches the pll
                    next_st.r.len_lo = wbyte;
                    next_st.line_len = {st.r.len_hi[5:0], wbyte};
                    next_st.line_len_load = 1'b1;
                end
                IDX_PHASE: next_st.r.phase = wbyte & MASK_SIX;
                IDX_HOLD_PRE: next_st.r.hold_pre = wbyte;
                IDX_HOLD_POST: next_st.r.hold_post = wbyte;
                IDX_SRC_CTRL: next_st.r.src_ctrl = wbyte & MASK_SRC_CTRL;
                IDX_CLAMP_HI: next_st.r.clamp_hi = wbyte & MASK_SIX;
                IDX_CLAMP_LO: next_st.r.clamp_lo = wbyte;
                IDX_CLAMP_WIDTH: next_st.r.clamp_width = wbyte;
                IDX_FRONT_CTRL: next_st.r.front_ctrl = wbyte & MASK_FRONT_CTRL;
                default: ;
            endcase
        end

        // pll source and edge controls
        next_st.lock_pulse = st.r.src_ctrl[SRC_LOCK_EDGE] ? hs_rise : hs_fall;
        next_st.clock_invert_pin_out = st.r.src_ctrl[SRC_CLOCK_INVERT_PIN_EN] && st.ci_sy[1];
        if (st.r.src_ctrl[SRC_HOLD_EXT]) begin
            next_st.hold = st.eh_sy[1] ^ st.r.src_ctrl[SRC_HOLD_POL];
        end else begin
            next_st.hold = int_hold;
        end
        next_st.ext_clk_sel = st.r.src_ctrl[SRC_EXT_CLK];
        // each step is 1/64 of a pixel period, the pll does the actual delay
        next_st.phase_steps = st.r.phase[5:0];

        // pixel counter from the raw hsync trailing edge
        next_st.black_start = start_hit;
        if (hs_fall) begin
            next_st.pix_cnt = 14'h0000;
            next_st.pix_run = 1'b1;
        end else if (start_hit) begin
            next_st.pix_run = 1'b0;
        end else if (st.pix_run && pix_tick && st.pix_cnt != PIX_CNT_MAX) begin
            next_st.pix_cnt = st.pix_cnt + 14'h0001;
        end

        // restore clamp, counted in pixel ticks
        if (dc_coupled) begin
            next_st.clamp_on = 1'b0;
            next_st.clamp_left = 8'h00;
        end else if (start_hit && st.r.clamp_width != 8'h00) begin
            next_st.clamp_on = 1'b1;
            next_st.clamp_left = st.r.clamp_width;
        end else if (st.clamp_on && pix_tick) begin
            next_st.clamp_left = st.clamp_left - 8'h01;
            next_st.clamp_on = st.clamp_left != 8'h01;
        end

        // offsets: dac word with correction off, signed digital offset with it on
        next_st.red_lsbs = st.r.red_ofs_lo[7:6];
        if (black_corr) begin
            next_st.grn_dac = OFS_MID;
            next_st.blu_dac = OFS_MID;
            next_st.grn_dig = pcor_ofs_signed(grn_word);
            next_st.blu_dig = pcor_ofs_signed(blu_word);
        end else begin
            next_st.grn_dac = grn_word;
            next_st.blu_dac = blu_word;
            next_st.grn_dig = 10'h000;
            next_st.blu_dig = 10'h000;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign pll_line_length = st.line_len;
    assign pll_line_length_load = st.line_len_load;
    assign sample_phase_steps = st.phase_steps;
    assign pll_hold = st.hold;
    assign pll_lock_pulse = st.lock_pulse;
    assign clock_invert_out = st.clock_invert_pin_out;
    assign use_external_pixel_clock = st.ext_clk_sel;
    assign clamp_on = st.clamp_on;
    assign black_sample_start = st.black_start;
    assign red_offset_lsbs = st.red_lsbs;
    assign green_offset_dac = st.grn_dac;
    assign blue_offset_dac = st.blu_dac;
    assign green_digital_offset = st.grn_dig;
    assign blue_digital_offset = st.blu_dig;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_len_lo_write;
        avs_write && !avs_waitrequest && avs_byteenable[0] && idx == IDX_LEN_LO;
    endsequence
    sequence s_red_lo_read;
        avs_read && avs_waitrequest && idx == IDX_RED_OFS_LO;
    endsequence

    sequence s_clamp_last;
        clamp_on && pix_tick && st.clamp_left == 8'h01 && !start_hit;
    endsequence
    sequence s_phase_write;
        avs_write && !avs_waitrequest && avs_byteenable[0] && idx == IDX_PHASE;
    endsequence

    a_bus_one_wait: assert property (s_req_seen |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    a_len_load: assert property (s_len_lo_write |=> pll_line_length_load &&
        pll_line_length == {$past(st.r.len_hi[5:0]), $past(avs_writedata[7:0])})
        else $error("line length not loaded on low write");
    a_len_no_load: assert property (!(avs_write && !avs_waitrequest && idx == IDX_LEN_LO) |=>
        !pll_line_length_load)
        else $error("line length loaded without low write");
    a_red_read_zero: assert property (s_red_lo_read |=> !avs_waitrequest && avs_readdata[5:0] == 6'h00)
        else $error("unused offset bits read nonzero");
    a_lock_trailing: assert property (hs_fall && !st.r.src_ctrl[SRC_LOCK_EDGE] |=> pll_lock_pulse)
        else $error("no lock pulse on trailing edge");
    a_lock_leading: assert property (hs_rise && st.r.src_ctrl[SRC_LOCK_EDGE] |=> pll_lock_pulse)
        else $error("no lock pulse on leading edge");
    a_clock_invert_pin_ignored: assert property (!st.r.src_ctrl[SRC_CLOCK_INVERT_PIN_EN] |=> !clock_invert_out)
        else $error("clock invert pin not ignored");
    a_hold_external: assert property (st.r.src_ctrl[SRC_HOLD_EXT] |=>
        pll_hold == ($past(st.eh_sy[1]) ^ $past(st.r.src_ctrl[SRC_HOLD_POL])))
        else $error("external hold not followed");
    a_hold_internal: assert property (!st.r.src_ctrl[SRC_HOLD_EXT] |=> pll_hold == $past(int_hold))
        else $error("internal hold not followed");
    a_clock_source: assert property ($changed(st.r.src_ctrl[SRC_EXT_CLK]) |=>
        use_external_pixel_clock == $past(st.r.src_ctrl[SRC_EXT_CLK]))
        else $error("clock source select lags");
    a_clamp_start: assert property (start_hit && !dc_coupled && st.r.clamp_width != 8'h00 |=>
        clamp_on && black_sample_start)
        else $error("clamp not started at start pixel");
    a_clamp_zero: assert property (st.r.clamp_width == 8'h00 |=> !$rose(clamp_on))
        else $error("clamp connected with zero width");
    a_clamp_dc: assert property (dc_coupled |=> !clamp_on)
        else $error("clamp active on dc inputs");
    a_clamp_end: assert property (s_clamp_last |=> !clamp_on)
        else $error("clamp outlasts its width");
    a_phase_write: assert property (s_phase_write |=> ##1
        sample_phase_steps == $past(avs_writedata[5:0], 2))
        else $error("phase code not applied");
    a_len_hi_unused: assert property (avs_write && !avs_waitrequest && idx == IDX_LEN_HI |=>
        st.r.len_hi[7:6] == 2'b00)
        else $error("unused length bits kept");
    a_ofs_dac: assert property (!black_corr |=> green_offset_dac == $past(grn_word) &&
        green_digital_offset == 10'h000)
        else $error("offset not routed to dac");
    a_ofs_signed: assert property (black_corr |=>
        blue_digital_offset == {~$past(blu_word[9]), $past(blu_word[8:0])})
        else $error("digital offset not signed");

endmodule

// File: pll_clamp_offset_regs_tb.sv
// Purpose: self-checking bench of the pll, clamp and offset register bank
// Assumes: one wait state per access, pins pass two sync flops
// Notes: pix_tick runs every cycle except in the half rate clamp test, where width is counted in ticks
`timescale 1ns/1ps
module pll_clamp_offset_regs_tb;
    import pcor_pkg::*;
    logic clk_sys = 0, resetn = 0, rd_en = 0, wr_en = 0, wait_req, load, hold, lock, cinv, extclk, clamp, bss;
    logic hs = 0, vs = 0, ehold = 0, cpin = 0, tick = 1, half_rate = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, v;
    logic [3:0] be = 4'h1;
    logic [13:0] len;
    logic [5:0] phase;
    logic [1:0] red_lsb;
    logic [9:0] gdac, bdac, gdig, bdig;
    logic [7:0] rst_tab [14] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h06, 8'h98, 8'h00, 8'h04, 8'h04, 8'h00,
        8'h00, 8'h02, 8'h10};
    int fail_count = 0, checked = 0, n_rise, n_fall, n_clamp, n_bss;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) tick <= half_rate ? !tick : 1'b1;
    pcor_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req),
        .hsync_pin(hs), .vsync_pin(vs), .ext_hold_pin(ehold), .clock_invert_pin(cpin), .pix_tick(tick),
        .pll_line_length(len), .pll_line_length_load(load), .sample_phase_steps(phase), .pll_hold(hold),
        .pll_lock_pulse(lock), .clock_invert_out(cinv), .use_external_pixel_clock(extclk), .clamp_on(clamp),
        .black_sample_start(bss), .red_offset_lsbs(red_lsb), .green_offset_dac(gdac), .blue_offset_dac(bdac),
        .green_digital_offset(gdig), .blue_digital_offset(bdig));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic access(input logic [5:0] idx, input logic wr, input logic [7:0] d, input logic [3:0] b);
        addr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        be <= b;
        rd_en <= !wr;
        wr_en <= wr;
        do @(posedge clk_sys); while (wait_req !== 1'b0);
        v = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask
    // derived outputs register one cycle after the register itself
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        access(idx, 1'b1, d, 4'h1);
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
        access(idx, 1'b0, 8'h00, 4'h1);
        chk("readdata", {24'h00_0000, e}, v);
    endtask
    task automatic pins_settle();
        repeat (6) @(posedge clk_sys);
    endtask
    // one hsync pulse: lock pulses counted apart for rise and fall windows
    task automatic hs_line();
        n_rise = 0;
        n_fall = 0;
        n_clamp = 0;
        n_bss = 0;
        hs <= 1'b1;
        repeat (12) begin
            @(posedge clk_sys);
            n_rise += lock;
        end
        hs <= 1'b0;
        repeat (60) begin
            @(posedge clk_sys);
            n_fall += lock;
            n_clamp += clamp;
            n_bss += bss;
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 14; i++) begin
            rd_chk(6'h19 + 6'(i), rst_tab[i]);
        end
        rd_chk(6'h30, 8'h01);
        rd_chk(6'h3f, 8'h00);
        $display("test reset values done");
        wr(6'h19, 8'hff);
        rd_chk(6'h19, 8'hc0);
        chk("red lsbs", 2'b11, red_lsb);
        wr(6'h1a, 8'h00);
        wr(6'h1b, 8'h40);
        chk("green dac on", 10'h200, gdac);
        chk("green digital", 10'h201, gdig);
        wr(6'h1c, 8'hff);
        wr(6'h1d, 8'hc0);
        chk("blue digital", 10'h1ff, bdig);
        wr(6'h30, 8'h00);
        chk("green dac off", 10'h001, gdac);
        chk("blue dac off", 10'h3ff, bdac);
        $display("test offsets done");
        wr(6'h1e, 8'hff);
        rd_chk(6'h1e, 8'h3f);
        chk("length held", 14'h0698, len);
        access(6'h1f, 1'b1, 8'h12, 4'h1);
        chk("length load", 1'b1, load);
        chk("length", 14'h3f12, len);
        wr(6'h20, 8'hff);
        chk("phase", 6'h3f, phase);
        access(6'h20, 1'b1, 8'h01, 4'h0);
        rd_chk(6'h20, 8'h3f);
        $display("test pll length and phase done");
        cpin <= 1'b1;
        vs <= 1'b1;
        pins_settle();
        chk("inv ignored", 1'b0, cinv);
        chk("internal hold", 1'b1, hold);
        vs <= 1'b0;
        wr(6'h23, 8'hff);
        rd_chk(6'h23, 8'h1f);
        pins_settle();
        chk("inv on", 1'b1, cinv);
        chk("ext clock", 1'b1, extclk);
        chk("hold low pol", 1'b1, hold);
        rd_chk(6'h31, 8'h05);
        ehold <= 1'b1;
        pins_settle();
        chk("hold low pol idle", 1'b0, hold);
        wr(6'h23, 8'h04);
        pins_settle();
        chk("hold high pol", 1'b1, hold);
        ehold <= 1'b0;
        pins_settle();
        chk("hold released", 1'b0, hold);
        $display("test source control done");
        hs_line();
        chk("lock trailing", 1, n_fall);
        chk("lock none rise", 0, n_rise);
        chk("clamp cycles", 16, n_clamp);
        chk("black start", 1, n_bss);
        wr(6'h23, 8'h01);
        wr(6'h26, 8'h05);
        hs_line();
        chk("lock leading", 1, n_rise);
        chk("clamp width 5", 5, n_clamp);
        wr(6'h26, 8'h00);
        hs_line();
        chk("clamp zero", 0, n_clamp);
        wr(6'h26, 8'h08);
        wr(6'h30, 8'h02);
        hs_line();
        chk("dc no clamp", 0, n_clamp);
        wr(6'h30, 8'h00);
        half_rate <= 1'b1;
        hs_line();
        chk("clamp pixel ticks", 16, n_clamp);
        chk("black start ticks", 1, n_bss);
        $display("test line timing done");
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
endmodule
